// >>> rtl/ptc_pin_sync.sv
`timescale 1ns/1ps
module ptc_pin_sync
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic agree;
  // a change counts once the second and third stages agree
  assign agree = (s2_q == s3_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise_q <= agree && s3_q && !lvl_q;
      fall_q <= agree && !s3_q && lvl_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule

// >>> rtl/ptc_pkg.sv
package ptc_pkg;

  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_C0 = 4'h0;
  localparam logic [3:0] REG_C1 = 4'h1;
  localparam logic [3:0] REG_DL = 4'h2;
  localparam logic [3:0] REG_DH = 4'h3;
  localparam logic [3:0] REG_AL = 4'h4;
  localparam logic [3:0] REG_AH = 4'h5;
  localparam logic [3:0] REG_RPL = 4'h6;
  localparam logic [3:0] REG_RPH = 4'h7;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] C0_WMASK = 8'hF8;
  localparam logic [7:0] HI_MASK_10 = 8'h03;
  localparam logic [7:0] HI_MASK_16 = 8'hFF;

  // ==========================================================
  // field positions
  localparam int C0_PAU = 7;
  localparam int C0_CK_HI = 6;
  localparam int C0_CK_LO = 4;
  localparam int C0_ON = 3;
  localparam int C1_M_HI = 7;
  localparam int C1_M_LO = 6;
  localparam int C1_IO_HI = 5;
  localparam int C1_IO_LO = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_CAPTS = 1;
  localparam int C1_CCLR = 0;
  localparam int STAT_AF = 0;
  localparam int STAT_PF = 1;

  // ==========================================================
  // encodings
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC = 2'h3;
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOG = 2'h3;
  localparam logic [1:0] PWM_INACT = 2'h0;
  localparam logic [1:0] PWM_ACT = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;
  localparam logic [1:0] PWM_ONE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;

  // ==========================================================
  // counter and prescaler
  localparam logic [15:0] CNT_MAX_10 = 16'h03FF;
  localparam logic [15:0] CNT_MAX_16 = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] SYS4_LAST = 2'h3;
  localparam logic [3:0] H16_LAST = 4'hF;
  localparam logic [5:0] H64_LAST = 6'h3F;

endpackage

// >>> rtl/ptc_tick_sel.sv
`timescale 1ns/1ps
module ptc_tick_sel
  import ptc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] sel,
  input wire logic high_tick,
  input wire logic sub_tick,
  input wire logic ext_rise,
  input wire logic ext_fall,
  output logic tick
);

  logic [1:0] sys_q, sys_d;
  logic [5:0] hi_q, hi_d;
  logic sys4_t, h16_t, h64_t;

  assign sys_d = sys_q + 2'h1;
  assign hi_d = high_tick ? hi_q + 6'h01 : hi_q;
  assign sys4_t = (sys_q == SYS4_LAST);
  assign h16_t = high_tick && (hi_q[3:0] == H16_LAST);
  assign h64_t = high_tick && (hi_q == H64_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      sys_q <= 2'h0;
      hi_q <= 6'h00;
    end else begin
      sys_q <= sys_d;
      hi_q <= hi_d;
    end
  end

  // source select, one strobe per counter clock
  assign tick = (sel == CK_SYS4) ? sys4_t :
                (sel == CK_SYS) ? 1'b1 :
                (sel == CK_H16) ? h16_t :
                (sel == CK_H64) ? h64_t :
                (sel == CK_SUB0 || sel == CK_SUB1) ? sub_tick :
                (sel == CK_EXTR) ? ext_rise :
                ext_fall;

endmodule

// >>> rtl/ptc_timer.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ptc_timer
  import ptc_pkg::*;
#(
  parameter bit WIDE = 1'b0
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  input wire logic HIGH_TICK,
  input wire logic SUB_TICK,
  input wire logic EXT_CLK_PIN,
  input wire logic CAP_PIN,
  output logic TMR_OUT,
  output logic TMR_OUT_OE,
  output logic A_MATCH,
  output logic P_MATCH
);

  // ==========================================================
  // bus decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  localparam logic [15:0] CNT_MAX = WIDE ? CNT_MAX_16 : CNT_MAX_10;
  localparam logic [7:0] HI_MASK = WIDE ? HI_MASK_16 : HI_MASK_10;

  logic wr_c0, wr_c1, wr_al, wr_ah, wr_rpl, wr_rph, wr_stat;
  assign wr_c0 = WR && hit(ADDR, REG_C0);
  assign wr_c1 = WR && hit(ADDR, REG_C1);
  assign wr_al = WR && hit(ADDR, REG_AL);
  assign wr_ah = WR && hit(ADDR, REG_AH);
  assign wr_rpl = WR && hit(ADDR, REG_RPL);
  assign wr_rph = WR && hit(ADDR, REG_RPH);
  assign wr_stat = WR && hit(ADDR, REG_STAT);

  // ==========================================================
  // registers
  logic [7:0] c0_q, c0_d, c1_q, c1_d, rdata_q, rdata_d;
  logic [15:0] comparator_a_value_q, comparator_a_value_d, comparator_p_value_q, comparator_p_value_d, cnt_q, cnt_d;
  logic af_q, af_d, pf_q, pf_d, out_lvl_q, out_lvl_d, pin_q, oe_q;
  logic am_q, pm_q;

  logic pau, on, pol, oc, capts, cclr;
  logic [2:0] ck_sel;
  logic [1:0] mode, io;
  assign pau = c0_q[C0_PAU];
  assign on = c0_q[C0_ON];
  assign ck_sel = c0_q[C0_CK_HI:C0_CK_LO];
  assign mode = c1_q[C1_M_HI:C1_M_LO];
  assign io = c1_q[C1_IO_HI:C1_IO_LO];
  assign oc = c1_q[C1_OC];
  assign pol = c1_q[C1_POL];
  assign capts = c1_q[C1_CAPTS];
  assign cclr = c1_q[C1_CCLR];

  // ==========================================================
  // pins and counter clock
  logic ext_lvl, ext_rise, ext_fall, cap_lvl, cap_rise, cap_fall, tick;

  ptc_pin_sync u_ext_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(EXT_CLK_PIN),
    .level(ext_lvl),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  ptc_pin_sync u_cap_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(CAP_PIN),
    .level(cap_lvl),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  ptc_tick_sel u_tick (
    .clk(CLK),
    .rst(SYS_RST),
    .sel(ck_sel),
    .high_tick(HIGH_TICK),
    .sub_tick(SUB_TICK),
    .ext_rise(ext_rise),
    .ext_fall(ext_fall),
    .tick(tick)
  );

  // ==========================================================
  // compare and clear
  logic on_rise, running, tick_run, p_clears, a_eq, p_eq, p_zero, at_max;
  logic a_hit, p_hit, ovf_hit, clr_now, sp_end;
  logic [15:0] cnt_inc;

  assign on_rise = wr_c0 && WDATA[C0_ON] && !on;
  assign running = on && !pau;
  assign tick_run = tick && running;
  // pwm and capture always clear on P
  assign p_clears = (mode == MODE_PWM) || (mode == MODE_CAP) || !cclr;
  assign a_eq = (cnt_q == comparator_a_value_q);
  assign p_eq = (cnt_q == comparator_p_value_q);
  assign p_zero = (comparator_p_value_q == CNT_ZERO);
  assign at_max = (cnt_q == CNT_MAX);
  assign a_hit = tick_run && a_eq && (mode != MODE_CAP);
  assign p_hit = tick_run && p_clears && !p_zero && p_eq;
  assign ovf_hit = tick_run && p_clears && p_zero && at_max;
  assign clr_now = (!p_clears && a_hit) || p_hit || ovf_hit;
  assign sp_end = a_hit && (mode == MODE_PWM) && (io == PWM_ONE);
  assign cnt_inc = (cnt_q + CNT_ONE) & CNT_MAX;

  assign cnt_d = on_rise ? CNT_ZERO :
                 !tick_run ? cnt_q :
                 clr_now ? CNT_ZERO :
                 cnt_inc;

  // ==========================================================
  // capture
  logic src_rise, src_fall, cap_evt;
  assign src_rise = capts ? ext_rise : cap_rise;
  assign src_fall = capts ? ext_fall : cap_fall;
  assign cap_evt = on && (mode == MODE_CAP) &&
                   (((io == CAP_RISE) && src_rise) ||
                    ((io == CAP_FALL) && src_fall) ||
                    ((io == CAP_BOTH) && (src_rise || src_fall)));

  // ==========================================================
  // register next values
  assign c0_d = wr_c0 ? (WDATA & C0_WMASK) :
                sp_end ? (c0_q & ~(8'h01 << C0_ON)) :
                c0_q;
  assign c1_d = wr_c1 ? WDATA : c1_q;
  assign comparator_a_value_d = cap_evt ? cnt_q :
                  wr_al ? {comparator_a_value_q[15:8], WDATA} :
                  wr_ah ? {WDATA & HI_MASK, comparator_a_value_q[7:0]} :
                  comparator_a_value_q;
  assign comparator_p_value_d = wr_rpl ? {comparator_p_value_q[15:8], WDATA} :
                  wr_rph ? {WDATA & HI_MASK, comparator_p_value_q[7:0]} :
                  comparator_p_value_q;
  // hardware set wins over a write-one clear
  assign af_d = a_hit || cap_evt || (af_q && !(wr_stat && WDATA[STAT_AF]));
  assign pf_d = p_hit || ovf_hit || (pf_q && !(wr_stat && WDATA[STAT_PF]));

  // ==========================================================
  // output level
  logic cmp_lvl, pwm_act, pwm_lvl;
  assign cmp_lvl = (io == IO_LOW) ? 1'b0 :
                   (io == IO_HIGH) ? 1'b1 :
                   (io == IO_TOG) ? !out_lvl_q :
                   out_lvl_q;
  assign pwm_act = (io == PWM_ACT) ||
                   ((io == PWM_RUN) && on && (cnt_q < comparator_a_value_q)) ||
                   ((io == PWM_ONE) && on);
  assign pwm_lvl = pwm_act ? oc : !oc;
  assign out_lvl_d = (mode == MODE_PWM) ? pwm_lvl :
                     (mode != MODE_CMP) ? out_lvl_q :
                     on_rise ? WDATA[C0_ON] & oc | !WDATA[C0_ON] & out_lvl_q :
                     a_hit ? cmp_lvl :
                     out_lvl_q;

  // ==========================================================
  // read mux
  assign rdata_d = hit(ADDR, REG_C0) ? c0_q :
                   hit(ADDR, REG_C1) ? c1_q :
                   hit(ADDR, REG_DL) ? cnt_q[7:0] :
                   hit(ADDR, REG_DH) ? cnt_q[15:8] :
                   hit(ADDR, REG_AL) ? comparator_a_value_q[7:0] :
                   hit(ADDR, REG_AH) ? comparator_a_value_q[15:8] :
                   hit(ADDR, REG_RPL) ? comparator_p_value_q[7:0] :
                   hit(ADDR, REG_RPH) ? comparator_p_value_q[15:8] :
                   hit(ADDR, REG_STAT) ? {6'h00, pf_q, af_q} :
                   REG_RST;

  // ==========================================================
  // state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      c0_q <= REG_RST;
      c1_q <= REG_RST;
      comparator_a_value_q <= CNT_ZERO;
      comparator_p_value_q <= CNT_ZERO;
      cnt_q <= CNT_ZERO;
      af_q <= 1'b0;
      pf_q <= 1'b0;
      am_q <= 1'b0;
      pm_q <= 1'b0;
      rdata_q <= REG_RST;
    end else begin
      c0_q <= c0_d;
      c1_q <= c1_d;
      comparator_a_value_q <= comparator_a_value_d;
      comparator_p_value_q <= comparator_p_value_d;
      cnt_q <= cnt_d;
      af_q <= af_d;
      pf_q <= pf_d;
      am_q <= a_hit;
      pm_q <= p_hit || ovf_hit;
      rdata_q <= RD ? rdata_d : REG_RST;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      out_lvl_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      out_lvl_q <= out_lvl_d;
      pin_q <= out_lvl_q ^ pol;
      oe_q <= (mode == MODE_CMP) || (mode == MODE_PWM);
    end
  end

  assign RDATA = rdata_q;
  assign TMR_OUT = pin_q;
  assign TMR_OUT_OE = oe_q;
  assign A_MATCH = am_q;
  assign P_MATCH = pm_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  pause_hold_a: assert property (
    on && pau && !wr_c0 |=> $stable(cnt_q))
    else $error("counter moved while paused");

  on_clear_a: assert property (
    on_rise |=> (cnt_q == CNT_ZERO) && on)
    else $error("counter not cleared on switch on");

  off_hold_a: assert property (
    !on && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while off");

  init_level_a: assert property (
    on_rise && (mode == MODE_CMP) |=> out_lvl_q == $past(oc) ##1
      TMR_OUT == ($past(out_lvl_q) ^ $past(pol)))
    else $error("initial level not restored");

  tc_release_a: assert property (
    (mode == MODE_TC) && !wr_c1 |=> !TMR_OUT_OE)
    else $error("pin driven in counter mode");

  match_low_a: assert property (
    (mode == MODE_CMP) && a_hit && (io == IO_LOW) && !on_rise |=> !out_lvl_q)
    else $error("match did not drive low");

  toggle_out_a: assert property (
    (mode == MODE_CMP) && a_hit && (io == IO_TOG) && !on_rise |=> out_lvl_q != $past(out_lvl_q))
    else $error("match did not toggle");

  a_clear_a: assert property (
    (mode == MODE_CMP) && cclr && a_hit && !on_rise |=> cnt_q == CNT_ZERO)
    else $error("A match did not clear counter");

  no_pflag_a: assert property (
    (mode == MODE_CMP) && cclr && !pf_q && !wr_c1 |=> !pf_q ##1 !P_MATCH)
    else $error("P flag raised with A clear");

  hi_zero_a: assert property (
    RD && hit(ADDR, REG_AH) && !WIDE |=> RDATA[7:2] == 6'h00)
    else $error("unimplemented high bits read nonzero");

endmodule

// >>> testbench/periodic_timer_control_tb.sv
`timescale 1ns/1ps
module periodic_timer_control_tb;
  import ptc_pkg::*;
  // ====================
  // wiring
  logic CLK, SYS_RST, WR, RD, HIGH_TICK, TMR_OUT, TMR_OUT_OE;
  logic SUB_TICK = 1'b0;
  logic A_MATCH, P_MATCH, EXT_CLK_PIN, CAP_PIN, ext_run, ext_lvl, cap_lvl;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA;
  int n_mismatch = 0;
  int checks = 0;
  ptc_timer i_ptc_timer (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .HIGH_TICK(HIGH_TICK), .SUB_TICK(SUB_TICK),
    .EXT_CLK_PIN(EXT_CLK_PIN), .CAP_PIN(CAP_PIN), .TMR_OUT(TMR_OUT),
    .TMR_OUT_OE(TMR_OUT_OE), .A_MATCH(A_MATCH), .P_MATCH(P_MATCH));
  ptc_pins_model i_ptc_pins_model (.clk(CLK), .run(ext_run), .ext_lvl(ext_lvl),
    .cap_lvl(cap_lvl), .ext_pin(EXT_CLK_PIN), .cap_pin(CAP_PIN));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) SUB_TICK <= ~SUB_TICK;
  // ====================
  // bus and helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    v = RDATA;
  endtask
  task automatic cnt(output logic [15:0] v);
    rd(REG_DL, v[7:0]);
    rd(REG_DH, v[15:8]);
  endtask
  task automatic ctl(input logic p, input logic [2:0] ck, input logic on);
    wr(REG_C0, {p, ck, on, 3'h0});
  endtask
  task automatic setup(input logic [7:0] c1, input logic [15:0] a, input logic [15:0] p);
    ctl(1'b0, CK_SYS, 1'b0);
    wr(REG_C1, c1);
    wr(REG_AL, a[7:0]);
    wr(REG_AH, a[15:8]);
    wr(REG_RPL, p[7:0]);
    wr(REG_RPH, p[15:8]);
    wr(REG_STAT, 8'h03);
  endtask
  task automatic waitm(input bit wp, input int lim, output int n);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (!(wp ? P_MATCH : A_MATCH) && n < lim);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    logic [3:0] ad[8] = '{REG_C1, REG_AL, REG_AH, REG_RPL, REG_RPH, REG_C0, REG_DL, 4'h9};
    logic [7:0] ex[8] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'hF8, 8'h00, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], v);
      chk("reset value", 8'h00, v);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ad[i], 8'hFF);
      rd(ad[i], v);
      chk("readback", ex[i], v);
    end
  endtask
  task automatic t_out();
    int n;
    logic lv;
    for (int k = 0; k < 8; k++) begin
      setup({MODE_CMP, k[1:0], 1'b1, k[2], 2'h1}, 16'h0002, 16'h0000);
      ctl(1'b0, CK_SYS, 1'b1);
      repeat (3) @(negedge CLK);
      chk("initial level", 1'b1 ^ k[2], TMR_OUT);
      waitm(1'b0, 20, n);
      @(negedge CLK);
      lv = (k[1:0] == IO_LOW || k[1:0] == IO_TOG) ? 1'b0 : 1'b1;
      chk("level after match", lv ^ k[2], TMR_OUT);
      chk("output enable", 1'b1, TMR_OUT_OE);
      waitm(1'b0, 20, n);
      // one negedge of the period was spent on the level check above
      chk("a clear period", 3, n + 1);
      waitm(1'b1, 30, n);
      chk("p match absent", 30, n);
    end
  endtask
  task automatic t_hold();
    logic [15:0] v1, v2;
    setup({MODE_TC, 6'h00}, 16'h0000, 16'h0000);
    ctl(1'b0, CK_SYS, 1'b1);
    repeat (40) @(posedge CLK);
    ctl(1'b1, CK_SYS, 1'b1);
    cnt(v1);
    repeat (10) @(posedge CLK);
    cnt(v2);
    chk("paused count", v1, v2);
    ctl(1'b0, CK_SYS, 1'b1);
    repeat (10) @(posedge CLK);
    cnt(v2);
    chk("resumed count", 1'b1, v2 > v1 + 16'h0008 && v2 < v1 + 16'h0020);
    ctl(1'b0, CK_SYS, 1'b0);
    cnt(v1);
    repeat (10) @(posedge CLK);
    cnt(v2);
    chk("count while off", v1, v2);
    ctl(1'b0, CK_SYS, 1'b1);
    cnt(v2);
    chk("count after on", 1'b1, v2 < 16'h0004);
  endtask
  task automatic t_clock();
    int ex[8] = '{64, 256, 16, 4, 128, 128, 32, 32};
    logic [15:0] v;
    setup({MODE_TC, 6'h00}, 16'h0000, 16'h0000);
    ext_run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      ctl(1'b0, s[2:0], 1'b0);
      ctl(1'b0, s[2:0], 1'b1);
      repeat (256) @(posedge CLK);
      ctl(1'b1, s[2:0], 1'b1);
      cnt(v);
      chk("ticks counted", 1'b1, v + 16'h0003 >= ex[s] && v <= ex[s] + 3);
    end
    ext_run <= 1'b0;
  endtask
  task automatic t_period();
    int n;
    logic [7:0] v;
    setup({MODE_CMP, 6'h00}, 16'h0002, 16'h0004);
    ctl(1'b0, CK_SYS, 1'b1);
    waitm(1'b1, 20, n);
    waitm(1'b1, 20, n);
    chk("p clear period", 5, n);
    rd(REG_STAT, v);
    chk("match flags", 8'h03, v);
    setup({MODE_PWM, PWM_RUN, 4'h9}, 16'h0002, 16'h0004);
    ctl(1'b0, CK_SYS, 1'b1);
    waitm(1'b1, 20, n);
    waitm(1'b1, 20, n);
    chk("pwm period", 5, n);
    setup({MODE_TC, 6'h00}, 16'h0100, 16'h0000);
    ctl(1'b0, CK_SYS, 1'b1);
    waitm(1'b1, 1100, n);
    waitm(1'b1, 1100, n);
    chk("overflow period", 1024, n);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 6; m++) begin
      setup(m < 4 ? {m[1:0], 6'h00} : {MODE_PWM, m[1:0], 4'h8}, 16'h0002, 16'h0004);
      ctl(1'b0, CK_SYS, 1'b1);
      repeat (4) @(negedge CLK);
      chk("output enable", m != 1 && m != 3, TMR_OUT_OE);
      if (m > 3) begin
        chk("held pwm level", m[0], TMR_OUT);
      end
    end
  endtask
  task automatic t_capture();
    logic [7:0] v;
    logic ex;
    for (int k = 0; k < 8; k++) begin
      setup({MODE_CAP, k[1:0], 2'h0, k[2], 1'b0}, 16'h0000, 16'h0000);
      ctl(1'b0, CK_SYS, 1'b1);
      for (int e = 1; e >= 0; e--) begin
        wr(REG_STAT, 8'h03);
        ext_lvl <= k[2] & e[0];
        cap_lvl <= !k[2] & e[0];
        repeat (8) @(posedge CLK);
        rd(REG_STAT, v);
        ex = k[1:0] == CAP_BOTH || k[1:0] == (e[0] ? CAP_RISE : CAP_FALL);
        chk("capture flag", ex, v[STAT_AF]);
      end
    end
  endtask
  // ====================
  // main sequence
  initial begin
    SYS_RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    HIGH_TICK = 1'b1;
    ext_run = 1'b0;
    ext_lvl = 1'b0;
    cap_lvl = 1'b0;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_out();
    t_hold();
    t_clock();
    t_period();
    t_modes();
    t_capture();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge CLK);
    n_mismatch++;
    give_verdict();
  end
endmodule

// >>> testbench/ptc_pins_model.sv
`timescale 1ns/1ps
module ptc_pins_model (
  input wire logic clk,
  input wire logic run,
  input wire logic ext_lvl,
  input wire logic cap_lvl,
  output logic ext_pin,
  output logic cap_pin
);
  // ====================
  // external pins
  logic [2:0] ph_q;
  initial ph_q = 3'h0;
  // the clock pin only runs while enabled and follows ext_lvl at rest
  always @(posedge clk) begin
    ph_q <= run ? ph_q + 3'h1 : 3'h0;
  end
  assign ext_pin = run ? ph_q[2] : ext_lvl;
  assign cap_pin = cap_lvl;
endmodule
